// >>> pkg/qdsc_pkg.sv
package qdsc_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int SEL_MSB = 19;
    localparam int SEL_LSB = 16;
    localparam int DATA_MSB = 15;
    localparam int RB_LSB = 4;
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_WRITE_INPUT = 4'h1;
    localparam logic [3:0] CMD_UPDATE_CONV = 4'h2;
    localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
    localparam logic [3:0] CMD_POWER_MODE = 4'h4;
    localparam logic [3:0] CMD_STROBE_MASK = 4'h5;
    localparam logic [3:0] CMD_SOFT_RESET = 4'h6;
    localparam logic [3:0] CMD_CHAIN_ENABLE = 4'h8;
    localparam logic [3:0] CMD_READBACK = 4'h9;
    localparam logic CHAIN_ENABLE_RESET = 1'h0;
    localparam logic [7:0] POWER_MODES_RESET = 8'h00;
    localparam logic [3:0] STROBE_MASK_RESET = 4'h0;
    localparam logic [1:0] READBACK_SEL_RESET = 2'h0;
    localparam logic [15:0] CODE_RESET = 16'h0000;
    localparam logic [1:0] PM_NORMAL = 2'h0;
    localparam logic [1:0] PM_PULL_1K = 2'h1;
    localparam logic [1:0] PM_PULL_100K = 2'h2;
    localparam logic [1:0] PM_THREE_STATE = 2'h3;

    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] sel;
        logic [15:0] data;
    } qdsc_frame_t;
endpackage : qdsc_pkg

// >>> src/qdsc_sync.sv
`timescale 1ns/1ns
module qdsc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = din;
        sync_d = meta_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= INIT;
            sync_q <= INIT;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign dout = sync_q;
endmodule : qdsc_sync

// >>> src/qdsc_serial_ctrl.sv
`timescale 1ns/1ns
// Contract
// [R1] Frame is 24 bits MSB first: command, four selects D..A, data word.
// [R2] Sample input on falling serial clock while frame select low; execute on its rise.
// [R3] Command 0011 writes and updates selected channels regardless of load strobe.
// [R4] Command 1000 sets chain enable from DB0; reset value zero is standalone.
// [R5] In chained mode, bits past 24 clocks ripple out on serial output.
// [R6] Serial output changes on rising serial clock edge.
// [R7] Host holds frame select low for exactly 24 times N clocks.
// [R8] Frame ending off a multiple of 24 still executes shift register content.
// [R9] Frame select rise latches data and stops further shifting.
// [R10] Host sends exact clock burst, raising frame select after last clock.
// [R11] Command 1001 arms readback of one selected channel; data bits ignored.
// [R12] Readback selecting none or several channels reads channel A.
// [R13] Next frame's output: four undefined bits, then register bits 19 down to 4.
// [R14] Standalone: output enabled only during the readback transfer.
// [R15] Host reads via readback frame, then an all-zero no-operation frame.
// [R16] Command 0100 loads two power-mode bits per channel from DB7..DB0.
// [R17] Mode 00 normal, 01 1k pull, 10 100k pull, 11 three-state.
// [R18] Power-down keeps converter registers and still accepts their updates.
// [R19] Separate input and converter registers; transfer governed by load strobe.
// [R20] Strobe low during 0001 write: input and converter update at frame end.
// [R21] Strobe high during 0001: converter updates on next strobe falling edge.
// [R22] Command 0101 loads mask; masked channels ignore load strobe.
// [R23] Reset clears power modes and readback selection.
module qdsc_serial_ctrl
    import qdsc_pkg::*;
#(
    parameter int CODE_BITS = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic frame_sel_n,
    input wire logic serial_clk,
    input wire logic serial_data_in,
    input wire logic load_strobe_n,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    output logic [4*CODE_BITS-1:0] conv_codes,
    output logic [7:0] channel_power_modes,
    output logic chain_enable_bit
);
    logic [3:0] syncIn;
    logic selN;
    logic sclkS;
    logic ldacN;
    logic dataS;

    // Data rides the same two stages as the clock, so both stay aligned
    qdsc_sync #(.WIDTH(4), .INIT(4'he)) u_sync (
        .clk(clk),
        .rst(rst),
        .din({frame_sel_n, serial_clk, load_strobe_n, serial_data_in}),
        .dout(syncIn)
    );
    assign selN = syncIn[3];
    assign sclkS = syncIn[2];
    assign ldacN = syncIn[1];
    assign dataS = syncIn[0];

    logic sclk_q, sclk_d;
    logic selN_q, selN_d;
    logic ldacN_q, ldacN_d;
    logic [FRAME_BITS-1:0] shift_q, shift_d;
    logic [5:0] cnt_q, cnt_d;
    logic sdo_q, sdo_d;
    logic oe_q, oe_d;
    logic chainEn_q, chainEn_d;
    logic [7:0] pwr_q, pwr_d;
    logic [3:0] mask_q, mask_d;
    logic [3:0] pend_q, pend_d;
    logic [1:0] rbSel_q, rbSel_d;
    logic rbArmed_q, rbArmed_d;
    logic rbActive_q, rbActive_d;
    logic [FRAME_BITS-1:0] rbShift_q, rbShift_d;
    logic [CODE_BITS-1:0] inReg_q [4];
    logic [CODE_BITS-1:0] inReg_d [4];
    logic [CODE_BITS-1:0] conv_q [4];
    logic [CODE_BITS-1:0] conv_d [4];

    logic sclkRise, sclkFall, selRise, selFall, ldacFall;
    qdsc_frame_t frm;
    logic [CODE_BITS-1:0] word;

    assign sclkRise = sclkS & ~sclk_q;
    assign sclkFall = ~sclkS & sclk_q;
    assign selRise = selN & ~selN_q;
    assign selFall = ~selN & selN_q;
    assign ldacFall = ~ldacN & ldacN_q;
    assign frm = qdsc_frame_t'(shift_q);
    assign word = frm.data[DATA_MSB -: CODE_BITS];

    always_comb begin
        sclk_d = sclkS;
        selN_d = selN;
        ldacN_d = ldacN;
        shift_d = shift_q;
        cnt_d = cnt_q;
        sdo_d = sdo_q;
        oe_d = oe_q;
        chainEn_d = chainEn_q;
        pwr_d = pwr_q;
        mask_d = mask_q;
        pend_d = pend_q;
        rbSel_d = rbSel_q;
        rbArmed_d = rbArmed_q;
        rbActive_d = rbActive_q;
        rbShift_d = rbShift_q;
        inReg_d = inReg_q;
        conv_d = conv_q;

        if (selFall) begin
            cnt_d = 6'h00;
            if (rbArmed_q) begin
                rbActive_d = 1'b1; // [R13]
                // A zero stands at frame start, each rise brings the next bit from the top
                rbShift_d = {3'h0, conv_q[rbSel_q], 5'h0};
                rbArmed_d = 1'b0;
                oe_d = 1'b1; // [R14]
                sdo_d = 1'b0;
            end
        end

        if (!selN && !selFall && sclkFall) begin
            shift_d = {shift_q[FRAME_BITS-2:0], dataS}; // [R1] [R2]
            if (cnt_q != 6'h3f) begin
                cnt_d = cnt_q + 6'h01;
            end
        end

        if (!selN && sclkRise) begin
            if (rbActive_q) begin
                sdo_d = rbShift_q[FRAME_BITS-1]; // [R6] [R13]
                rbShift_d = {rbShift_q[FRAME_BITS-2:0], 1'b0};
            end else if (chainEn_q && cnt_q >= 6'(FRAME_BITS)) begin
                sdo_d = shift_q[FRAME_BITS-1]; // [R5] [R6]
            end
        end

        for (int ch = 0; ch < 4; ch++) begin
            if (ldacFall && pend_q[ch] && !mask_q[ch]) begin
                conv_d[ch] = inReg_q[ch]; // [R21] [R22]
                pend_d[ch] = 1'b0;
            end
        end

        if (selRise) begin
            // [R8] [R9] execute whatever was shifted
            if (rbActive_q) begin
                rbActive_d = 1'b0;
                oe_d = chainEn_q; // [R14]
            end
            unique case (frm.cmd)
                CMD_WRITE_INPUT: begin
                    for (int ch = 0; ch < 4; ch++) begin
                        if (frm.sel[ch]) begin
                            inReg_d[ch] = word; // [R19]
                            if (!ldacN && !mask_q[ch]) begin
                                conv_d[ch] = word; // [R20] [R18]
                                pend_d[ch] = 1'b0;
                            end else begin
                                pend_d[ch] = 1'b1; // [R21]
                            end
                        end
                    end
                end
                CMD_UPDATE_CONV: begin
                    for (int ch = 0; ch < 4; ch++) begin
                        if (frm.sel[ch]) begin
                            conv_d[ch] = inReg_q[ch];
                            pend_d[ch] = 1'b0;
                        end
                    end
                end
                CMD_WRITE_UPDATE: begin
                    for (int ch = 0; ch < 4; ch++) begin
                        if (frm.sel[ch]) begin
                            inReg_d[ch] = word;
                            conv_d[ch] = word; // [R3] [R18]
                            pend_d[ch] = 1'b0;
                        end
                    end
                end
                CMD_POWER_MODE: pwr_d = frm.data[7:0]; // [R16] [R17] [R18]
                CMD_STROBE_MASK: mask_d = frm.data[3:0]; // [R22]
                CMD_SOFT_RESET: begin
                    pwr_d = POWER_MODES_RESET; // [R23]
                    rbArmed_d = 1'b0;
                    mask_d = STROBE_MASK_RESET;
                    pend_d = 4'h0;
                    for (int ch = 0; ch < 4; ch++) begin
                        inReg_d[ch] = CODE_RESET[CODE_BITS-1:0];
                        conv_d[ch] = CODE_RESET[CODE_BITS-1:0];
                    end
                end
                CMD_CHAIN_ENABLE: begin
                    chainEn_d = frm.data[0]; // [R4]
                    oe_d = frm.data[0];
                end
                CMD_READBACK: begin
                    rbArmed_d = 1'b1; // [R11]
                    unique case (frm.sel)
                        4'h2: rbSel_d = 2'h1;
                        4'h4: rbSel_d = 2'h2;
                        4'h8: rbSel_d = 2'h3;
                        default: rbSel_d = 2'h0; // [R12]
                    endcase
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b1;
            selN_q <= 1'b1;
            ldacN_q <= 1'b1;
            shift_q <= '0;
            cnt_q <= 6'h00;
            sdo_q <= 1'b0;
            oe_q <= 1'b0;
            chainEn_q <= CHAIN_ENABLE_RESET; // [R4]
            pwr_q <= POWER_MODES_RESET; // [R23]
            mask_q <= STROBE_MASK_RESET;
            pend_q <= 4'h0;
            rbSel_q <= READBACK_SEL_RESET; // [R23]
            rbArmed_q <= 1'b0;
            rbActive_q <= 1'b0;
            rbShift_q <= '0;
            for (int ch = 0; ch < 4; ch++) begin
                inReg_q[ch] <= '0;
                conv_q[ch] <= '0;
            end
        end else begin
            sclk_q <= sclk_d;
            selN_q <= selN_d;
            ldacN_q <= ldacN_d;
            shift_q <= shift_d;
            cnt_q <= cnt_d;
            sdo_q <= sdo_d;
            oe_q <= oe_d;
            chainEn_q <= chainEn_d;
            pwr_q <= pwr_d;
            mask_q <= mask_d;
            pend_q <= pend_d;
            rbSel_q <= rbSel_d;
            rbArmed_q <= rbArmed_d;
            rbActive_q <= rbActive_d;
            rbShift_q <= rbShift_d;
            inReg_q <= inReg_d;
            conv_q <= conv_d;
        end
    end

    assign serial_data_out = sdo_q;
    assign serial_data_out_oe = oe_q;
    assign channel_power_modes = pwr_q;
    assign chain_enable_bit = chainEn_q;
    assign conv_codes = {conv_q[3], conv_q[2], conv_q[1], conv_q[0]};

    a_shift_frozen: assert property (@(posedge clk) disable iff (rst) // [R9]
        selN_q && selN |=> $stable(shift_q))
        else $error("shift register moved outside a frame");
    a_write_update: assert property (@(posedge clk) disable iff (rst) // [R3]
        selRise && frm.cmd == CMD_WRITE_UPDATE && frm.sel[0] |=> conv_q[0] == $past(word))
        else $error("write and update missed channel A");
    a_chain_set: assert property (@(posedge clk) disable iff (rst) // [R4]
        selRise && frm.cmd == CMD_CHAIN_ENABLE |=> chainEn_q == $past(frm.data[0]))
        else $error("chain enable not loaded");
    a_power_load: assert property (@(posedge clk) disable iff (rst) // [R16]
        selRise && frm.cmd == CMD_POWER_MODE |=> pwr_q == $past(frm.data[7:0]))
        else $error("power modes not loaded");
    a_power_keeps: assert property (@(posedge clk) disable iff (rst) // [R18]
        selRise && frm.cmd == CMD_POWER_MODE && !ldacFall |=> $stable(conv_q[0]))
        else $error("power mode write disturbed converter");
    a_rb_default: assert property (@(posedge clk) disable iff (rst) // [R12]
        selRise && frm.cmd == CMD_READBACK && frm.sel == 4'h0 |=> rbSel_q == 2'h0 && rbArmed_q)
        else $error("readback default not channel A");
    a_oe_standalone: assert property (@(posedge clk) disable iff (rst) // [R14]
        !chainEn_q && !rbActive_q && !$past(rbActive_q) |-> !oe_q)
        else $error("output enabled outside readback");
    a_strobe_mask: assert property (@(posedge clk) disable iff (rst) // [R22]
        ldacFall && mask_q[1] && !selRise |=> $stable(conv_q[1]))
        else $error("masked channel followed strobe");
    a_deferred_update: assert property (@(posedge clk) disable iff (rst) // [R21]
        ldacFall && pend_q[1] && !mask_q[1] && !selRise |=> conv_q[1] == $past(inReg_q[1]))
        else $error("deferred update missed");
    a_rb_enable: assert property (@(posedge clk) disable iff (rst) // [R14]
        selFall && rbArmed_q |=> oe_q && rbActive_q && !sdo_q)
        else $error("readback frame did not enable output");
    a_rb_load: assert property (@(posedge clk) disable iff (rst) // [R13]
        selFall && rbArmed_q |=> rbShift_q == {3'h0, $past(conv_q[rbSel_q]), 5'h0})
        else $error("readback word not loaded");
    a_sdo_steady: assert property (@(posedge clk) disable iff (rst) // [R6]
        !(sclkRise && !selN) && !selFall |=> $stable(sdo_q))
        else $error("serial output moved off a clock rise");
    a_strobe_low: assert property (@(posedge clk) disable iff (rst) // [R20]
        selRise && frm.cmd == CMD_WRITE_INPUT && frm.sel[3] && !ldacN && !mask_q[3] |=> conv_q[3] == $past(word))
        else $error("strobe low write missed converter");
    a_input_hold: assert property (@(posedge clk) disable iff (rst) // [R19]
        selRise && frm.cmd == CMD_WRITE_INPUT && frm.sel[1] && ldacN |=> $stable(conv_q[1]) && pend_q[1])
        else $error("strobe high write reached converter");
    a_update_conv: assert property (@(posedge clk) disable iff (rst) // [R19]
        selRise && frm.cmd == CMD_UPDATE_CONV && frm.sel[1] |=> conv_q[1] == $past(inReg_q[1]))
        else $error("update command missed channel B");
    a_soft_clear: assert property (@(posedge clk) disable iff (rst) // [R23]
        selRise && frm.cmd == CMD_SOFT_RESET |=> pwr_q == POWER_MODES_RESET && !rbArmed_q)
        else $error("soft reset left modes or readback");
endmodule : qdsc_serial_ctrl

// >>> sim/qdsc_host_model.sv
`timescale 1ns/1ns
module qdsc_host_model (
    input wire logic clk,
    input wire logic serialDataOut,
    output logic frameSelN,
    output logic serialClk,
    output logic serialDataIn
);
    initial begin
        frameSelN = 1'b1;
        serialClk = 1'b1;
        serialDataIn = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step

    // Exact burst of n clocks, data changed while clock is high
    task automatic send(input logic [71:0] bits, input int n, output logic [71:0] rx);
        rx = '0;
        step(1);
        frameSelN = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serialDataIn = bits[i];
            step(4);
            serialClk = 1'b0;
            rx = {rx[70:0], serialDataOut};
            step(4);
            serialClk = 1'b1;
        end
        step(4);
        frameSelN = 1'b1;
        serialDataIn = ~serialDataIn;
        step(6);
    endtask : send
endmodule : qdsc_host_model

// >>> sim/quad_dac_serial_control_tb.sv
`timescale 1ns/1ns
module quad_dac_serial_control_tb
    import qdsc_pkg::*;
;
    logic clk, rst, loadStrobeN, frameSelN, serialClk, serialDataIn;
    logic serialDataOut, serialDataOutOe, chainEnableBit;
    logic sdoPin;
    logic [63:0] convCodes;
    logic [7:0] channelPowerModes;
    logic [15:0] expCode [4];
    logic [71:0] rx;
    logic [23:0] fa, fb;
    int fails, compares;

    qdsc_serial_ctrl DUT (.clk(clk), .rst(rst), .frame_sel_n(frameSelN), .serial_clk(serialClk),
        .serial_data_in(serialDataIn), .load_strobe_n(loadStrobeN), .serial_data_out(serialDataOut),
        .serial_data_out_oe(serialDataOutOe), .conv_codes(convCodes),
        .channel_power_modes(channelPowerModes), .chain_enable_bit(chainEnableBit));
    // Released pin shows the inverse of the last bit
    assign sdoPin = serialDataOutOe ? serialDataOut : ~serialDataOut;
    qdsc_host_model HOST (.clk(clk), .serialDataOut(sdoPin), .frameSelN(frameSelN),
        .serialClk(serialClk), .serialDataIn(serialDataIn));

    initial clk = 1'b0;
    always #10 clk = ~clk;

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step

    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    function automatic logic [23:0] fr(input logic [3:0] c, input logic [3:0] s, input logic [15:0] d);
        qdsc_frame_t f;
        f = '{cmd: c, sel: s, data: d};
        return f;
    endfunction : fr

    task automatic wr(input logic [3:0] c, input logic [3:0] s, input logic [15:0] d);
        HOST.send({48'h0, fr(c, s, d)}, FRAME_BITS, rx);
        step(4);
    endtask : wr

    task automatic codes_ok(input string what);
        check(convCodes, {expCode[3], expCode[2], expCode[1], expCode[0]}, what);
    endtask : codes_ok

    task automatic t_reset;
        check({serialDataOutOe, chainEnableBit, channelPowerModes}, 64'h0, "reset outputs");
        codes_ok("reset codes");
        $display("done reset");
    endtask : t_reset

    task automatic t_write_update;
        wr(CMD_WRITE_UPDATE, 4'h5, 16'h1234);
        expCode[0] = 16'h1234;
        expCode[2] = 16'h1234;
        codes_ok("write update");
        $display("done write update");
    endtask : t_write_update

    task automatic t_deferred;
        wr(CMD_WRITE_INPUT, 4'h2, 16'habcd);
        codes_ok("held by strobe");
        loadStrobeN = 1'b0;
        step(8);
        expCode[1] = 16'habcd;
        codes_ok("strobe fall");
        wr(CMD_WRITE_INPUT, 4'h8, 16'h5a5a);
        expCode[3] = 16'h5a5a;
        codes_ok("strobe low write");
        loadStrobeN = 1'b1;
        step(8);
        $display("done deferred");
    endtask : t_deferred

    task automatic t_mask;
        wr(CMD_STROBE_MASK, 4'h0, 16'h0002);
        wr(CMD_WRITE_INPUT, 4'h2, 16'h1111);
        loadStrobeN = 1'b0;
        step(8);
        codes_ok("masked strobe");
        loadStrobeN = 1'b1;
        step(8);
        wr(CMD_UPDATE_CONV, 4'h2, 16'h0000);
        expCode[1] = 16'h1111;
        codes_ok("update command");
        wr(CMD_STROBE_MASK, 4'h0, 16'h0000);
        $display("done mask");
    endtask : t_mask

    task automatic t_power;
        wr(CMD_POWER_MODE, 4'hf, 16'hffe4);
        check(channelPowerModes, 64'he4, "power modes");
        codes_ok("codes kept");
        wr(CMD_WRITE_UPDATE, 4'h1, 16'h0bad);
        expCode[0] = 16'h0bad;
        codes_ok("update while down");
        wr(4'ha, 4'hf, 16'hffff);
        codes_ok("reserved command");
        wr(CMD_POWER_MODE, 4'hf, 16'h0000);
        check(channelPowerModes, 64'h0, "power up");
        $display("done power");
    endtask : t_power

    task automatic t_readback;
        logic [3:0] sels [3];
        int chans [3];
        sels = '{4'h4, 4'h6, 4'h0};
        chans = '{2, 0, 0};
        for (int i = 0; i < 3; i++) begin
            wr(CMD_READBACK, sels[i], 16'hffff);
            fork
                HOST.send({48'h0, fr(CMD_NOP, 4'h0, 16'h0000)}, FRAME_BITS, rx);
                begin
                    step(40);
                    check(serialDataOutOe, 64'h1, "output enabled");
                end
            join
            check(rx[19:4], expCode[chans[i]], "readback data");
            check(serialDataOutOe, 64'h0, "output disabled");
        end
        $display("done readback");
    endtask : t_readback

    task automatic t_chain;
        wr(CMD_CHAIN_ENABLE, 4'h0, 16'h0001);
        check(chainEnableBit, 64'h1, "chain on");
        fa = fr(CMD_WRITE_UPDATE, 4'h1, 16'h7777);
        fb = fr(CMD_WRITE_UPDATE, 4'h2, 16'h4321);
        HOST.send({24'h0, fa, fb}, 48, rx);
        step(4);
        check(rx[23:0], fa, "chain output");
        expCode[1] = 16'h4321;
        codes_ok("chain latch");
        HOST.send({42'h0, 6'h2a, fr(CMD_WRITE_UPDATE, 4'h8, 16'h0f0f)}, 30, rx);
        step(4);
        expCode[3] = 16'h0f0f;
        codes_ok("odd count");
        wr(CMD_CHAIN_ENABLE, 4'h0, 16'h0000);
        check(chainEnableBit, 64'h0, "chain off");
        $display("done chain");
    endtask : t_chain

    task automatic t_soft_reset;
        wr(CMD_POWER_MODE, 4'h0, 16'h001b);
        check(channelPowerModes, 64'h1b, "modes before reset");
        wr(CMD_READBACK, 4'h1, 16'h0000);
        wr(CMD_SOFT_RESET, 4'h0, 16'h0000);
        expCode = '{default: 16'h0};
        codes_ok("soft reset codes");
        check(channelPowerModes, 64'h0, "soft reset modes");
        fork
            HOST.send({48'h0, fr(CMD_NOP, 4'h0, 16'h0000)}, FRAME_BITS, rx);
            begin
                step(40);
                check(serialDataOutOe, 64'h0, "readback disarmed");
            end
        join
        $display("done soft reset");
    endtask : t_soft_reset

    task automatic finish_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    initial begin
        rst = 1'b1;
        loadStrobeN = 1'b1;
        fails = 0;
        compares = 0;
        expCode = '{default: 16'h0};
        repeat (6) @(posedge clk);
        #2;
        rst = 1'b0;
        step(4);
        t_reset();
        t_write_update();
        t_deferred();
        t_mask();
        t_power();
        t_readback();
        t_chain();
        t_soft_reset();
        finish_test();
    end

    initial begin
        #1000000;
        fails++;
        $display("BAD %0t watchdog expired", $time);
        finish_test();
    end
endmodule : quad_dac_serial_control_tb
